// File: rtl/pdl_top.sv
// Divider sync, path delays, digital lock detector and lock pin logic with APB registers.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pdl_top
  import pdl_pkg::*;
(
  input  wire logic        CORE_CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        REF_TICK_I,
  input  wire logic        FB_TICK_I,
  input  wire logic        DIV_ALIGN_N_I,
  input  wire logic        LOCK_INDICATOR_PIN_I,
  output logic             LOCK_INDICATOR_PIN_O,
  output logic             LOCK_INDICATOR_PIN_OE_O,
  output logic             LOCK_SRC_EN_O,
  output logic             STATUS_PIN_O,
  output logic             REFERENCE_WATCH_PIN_O,
  output logic             PHASE_CMP_REF_O,
  output logic             PHASE_CMP_FB_O
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  s_ref;
    logic [2:0]  s_fb;
    logic [1:0]  s_sync;
    logic [1:0]  s_cmp;
    logic [7:0]  r16;
    logic [7:0]  r17;
    logic [7:0]  r18;
    logic [7:0]  r19;
    logic [7:0]  r1a;
    logic [7:0]  r1b;
    logic [7:0]  ctrl;
    logic [13:0] rcnt;
    logic [12:0] bcnt;
    logic [5:0]  acnt;
    logic [31:0] prdata;
    pdl_lk_e     lk;
    logic [7:0]  dcnt;
    logic [7:0]  lcnt;
    logic        flag;
    logic        pin_o;
    logic        pin_oe;
    logic        pin_src;
    logic        st_o;
    logic        rw_o;
  } pdl_st_s;

  pdl_st_s     st_q;
  pdl_st_s     st_d;
  logic        apb_hit;
  logic [31:0] rd_val;
  logic        apb_wr;
  logic        pin_rst;
  logic        det_en;
  logic        done;
  logic [7:0]  diff;
  logic [7:0]  thr_lk;
  logic [7:0]  thr_ul;
  logic [7:0]  need;
  logic        ev_in;
  logic        ev_unl;

  pdl_path_if r_if ();
  pdl_path_if n_if ();

  // Feedback ratio from prescaler mode, swallow and main counts.
  function automatic logic [18:0] n_ratio(input logic [2:0]  psc,
                                          input logic [5:0]  a,
                                          input logic [12:0] b);
    logic [5:0]  p;
    logic [18:0] pb;
    case (psc)
      PSC_FIX1:   p = 6'h01;
      PSC_FIX2:   p = 6'h02;
      PSC_FIX3:   p = 6'h03;
      PSC_DUAL2:  p = 6'h02;
      PSC_DUAL4:  p = 6'h04;
      PSC_DUAL8:  p = 6'h08;
      PSC_DUAL16: p = 6'h10;
      default:    p = 6'h20;
    endcase
    pb = 19'(p) * 19'(b);
    if (b == 13'h0001) begin
      n_ratio = 19'(p);
    end else if (psc >= PSC_DUAL2) begin
      n_ratio = pb + 19'(a);
    end else begin
      n_ratio = pb;
    end
  endfunction

  // ----------------------------------------------------------------
  // Divider paths
  // ----------------------------------------------------------------
  // Align pin reset acts only when its field is nonzero.
  assign pin_rst = (st_q.r19[F_PRST_LO +: 2] != 2'b00) && !st_q.s_sync[1];

  // Synchronised rising edges feed the counters; software bits hold them in reset.
  assign r_if.tick   = st_q.s_ref[1] & ~st_q.s_ref[2];
  assign n_if.tick   = st_q.s_fb[1] & ~st_q.s_fb[2];
  assign r_if.clr    = st_q.ctrl[F_SHRST] | st_q.ctrl[F_RRST] | pin_rst;
  assign n_if.clr    = st_q.ctrl[F_SHRST] | st_q.ctrl[F_ABRST] | pin_rst;
  assign r_if.ratio  = {5'h00, st_q.rcnt};
  // The swallow count and prescaler limits are the configuring party's duty.
  assign n_if.ratio  = n_ratio(st_q.r16[2:0], st_q.acnt, st_q.bcnt);
  assign r_if.dly_en = st_q.ctrl[F_RDEN];
  assign n_if.dly_en = st_q.ctrl[F_NDEN];
  assign r_if.code   = st_q.r19[F_RDLY_LO +: 3];
  assign n_if.code   = st_q.r19[F_NDLY_LO +: 3];

  pdl_div u_rdiv (
    .clk_i (CORE_CLK_I),
    .rst_i (SYS_RST_I),
    .p     (r_if)
  );

  pdl_div u_ndiv (
    .clk_i (CORE_CLK_I),
    .rst_i (SYS_RST_I),
    .p     (n_if)
  );

  pdl_dly u_rdly (
    .clk_i (CORE_CLK_I),
    .rst_i (SYS_RST_I),
    .p     (r_if)
  );

  pdl_dly u_ndly (
    .clk_i (CORE_CLK_I),
    .rst_i (SYS_RST_I),
    .p     (n_if)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Read data and address hit for the current address.
  always_comb begin
    apb_hit = 1'b1;
    case (PADDR_I)
      addr(IDX_RCNT):  rd_val = {18'h00000, st_q.rcnt};
      addr(IDX_NCNT):  rd_val = {10'h000, st_q.acnt, 3'h0, st_q.bcnt};
      addr(IDX_PSC):   rd_val = {24'h000000, st_q.r16};
      addr(IDX_STSEL): rd_val = {24'h000000, st_q.r17};
      addr(IDX_LKCFG): rd_val = {24'h000000, st_q.r18};
      addr(IDX_SYNC):  rd_val = {24'h000000, st_q.r19};
      addr(IDX_LKPIN): rd_val = {24'h000000, st_q.r1a};
      addr(IDX_RWSEL): rd_val = {24'h000000, st_q.r1b};
      addr(IDX_CTRL):  rd_val = {24'h000000, st_q.ctrl};
      addr(IDX_STAT):  rd_val = {29'h00000000, pin_rst, st_q.s_cmp[1], st_q.flag};
      default: begin
        rd_val = 32'h00000000;
        apb_hit = 1'b0;
      end
    endcase
  end

  assign apb_wr    = PSEL_I & PENABLE_I & PWRITE_I & apb_hit;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~apb_hit;

  // ----------------------------------------------------------------
  // Lock thresholds
  // ----------------------------------------------------------------
  // Thresholds and the required run length follow the window settings.
  always_comb begin
    det_en = ~st_q.r18[F_DIS];
    thr_lk = lk_thr(st_q.r18[F_WIN], st_q.r17[1:0]);
    thr_ul = {thr_lk[6:0], 1'b0};
    case (st_q.r18[F_CNT_LO +: 2])
      2'b00:   need = LKN_0;
      2'b01:   need = LKN_1;
      2'b10:   need = LKN_2;
      default: need = LKN_3;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Synchronisers, register writes, lock detector and pin drivers.
  always_comb begin
    st_d = st_q;
    done = 1'b0;
    diff = 8'h00;
    st_d.s_ref  = {st_q.s_ref[1:0], REF_TICK_I};
    st_d.s_fb   = {st_q.s_fb[1:0], FB_TICK_I};
    st_d.s_sync = {st_q.s_sync[0], DIV_ALIGN_N_I};
    st_d.s_cmp  = {st_q.s_cmp[0], LOCK_INDICATOR_PIN_I};
    // Read data is captured in the setup cycle.
    if (PSEL_I && !PENABLE_I) begin
      st_d.prdata = rd_val;
    end
    // Writes land at the end of the access phase; reset bits stay as written.
    if (apb_wr) begin
      case (PADDR_I)
        addr(IDX_RCNT):  st_d.rcnt = PWDATA_I[13:0];
        addr(IDX_NCNT): begin
          st_d.bcnt = PWDATA_I[12:0];
          st_d.acnt = PWDATA_I[F_A_LO +: 6];
        end
        addr(IDX_PSC):   st_d.r16 = {5'h00, PWDATA_I[2:0]};
        addr(IDX_STSEL): st_d.r17 = PWDATA_I[7:0];
        addr(IDX_LKCFG): st_d.r18 = {1'b0, PWDATA_I[6:3], 3'h0};
        addr(IDX_SYNC):  st_d.r19 = PWDATA_I[7:0];
        addr(IDX_LKPIN): st_d.r1a = {2'b00, PWDATA_I[5:0]};
        addr(IDX_RWSEL): st_d.r1b = {3'h0, PWDATA_I[4:0]};
        addr(IDX_CTRL):  st_d.ctrl = {3'h0, PWDATA_I[4:0]};
        default: ;
      endcase
    end
    // Measure the gap between the two delayed edges; an overlong gap ends the cycle.
    case (st_q.lk)
      LK_IDLE: begin
        if (r_if.out && n_if.out) begin
          done = 1'b1;
        end else if (r_if.out || n_if.out) begin
          st_d.lk = LK_MEAS;
          st_d.dcnt = 8'h01;
        end
      end
      LK_MEAS: begin
        if (r_if.out || n_if.out || st_q.dcnt > thr_ul) begin
          done = 1'b1;
          diff = st_q.dcnt;
          st_d.lk = LK_IDLE;
        end else begin
          st_d.dcnt = st_q.dcnt + 8'h01;
        end
      end
      default: st_d.lk = LK_IDLE;
    endcase
    ev_in  = det_en && done && diff < thr_lk;
    ev_unl = det_en && done && diff > thr_ul;
    // Consecutive in-lock cycles raise the flag; one wide gap drops it.
    if (ev_in) begin
      if (st_q.lcnt != 8'hFF) begin
        st_d.lcnt = st_q.lcnt + 8'h01;
      end
      if (st_q.lcnt + 8'h01 >= need) begin
        st_d.flag = 1'b1;
      end
    end else if (ev_unl) begin
      st_d.flag = 1'b0;
      st_d.lcnt = 8'h00;
    end else if (done) begin
      st_d.lcnt = 8'h00;
    end
    // A disabled detector sits idle with the flag low.
    if (!det_en) begin
      st_d.lk = LK_IDLE;
      st_d.flag = 1'b0;
      st_d.lcnt = 8'h00;
      st_d.dcnt = 8'h00;
    end
    // Lock indicator pin: flag, two pulse styles or the current source.
    st_d.pin_o = 1'b0;
    st_d.pin_oe = 1'b0;
    st_d.pin_src = 1'b0;
    case (st_q.r1a[5:0])
      LKM_FLAG: begin
        st_d.pin_oe = 1'b1;
        st_d.pin_o = st_q.flag;
      end
      LKM_NPULSE: st_d.pin_oe = (st_q.lk == LK_MEAS);
      LKM_PPULSE: begin
        st_d.pin_oe = (st_q.lk == LK_MEAS);
        st_d.pin_o = 1'b1;
      end
      LKM_CSRC: begin
        st_d.pin_src = st_q.flag;
        st_d.pin_oe = ~st_q.flag;
      end
      default: ;
    endcase
    st_d.st_o = osel(st_q.r17[7:2], st_q.flag, st_q.s_cmp[1]);
    st_d.rw_o = osel({1'b0, st_q.r1b[4:0]}, st_q.flag, st_q.s_cmp[1]);
  end

  // ----------------------------------------------------------------
  // Registers and outputs
  // ----------------------------------------------------------------
  // State register; the align pin idles high so no reset is seen at start.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      st_q <= '0;
      st_q.lk <= LK_IDLE;
      st_q.s_sync <= 2'b11;
    end else begin
      st_q <= st_d;
    end
  end

  assign PRDATA_O                = st_q.prdata;
  assign LOCK_INDICATOR_PIN_O    = st_q.pin_o;
  assign LOCK_INDICATOR_PIN_OE_O = st_q.pin_oe;
  assign LOCK_SRC_EN_O           = st_q.pin_src;
  assign STATUS_PIN_O            = st_q.st_o;
  assign REFERENCE_WATCH_PIN_O   = st_q.rw_o;
  assign PHASE_CMP_REF_O         = r_if.out;
  assign PHASE_CMP_FB_O          = n_if.out;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_PIN_RST: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (st_q.r19[F_PRST_LO +: 2] != 2'b00 && !st_q.s_sync[1]) |-> (r_if.clr && n_if.clr))
    else $error("align pin did not clear counters");
  AST_PIN_DEF: assert property (@(posedge CORE_CLK_I)
    $fell(SYS_RST_I) |-> (st_q.r19 == RST_BYTE && !pin_rst))
    else $error("align pin reset enabled after reset");
  AST_LOCK_RISE: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    $rose(st_q.flag) |-> $past(ev_in && st_q.lcnt + 8'h01 >= need))
    else $error("lock flag rose without enough in-lock cycles");
  AST_FIVE: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    ($rose(st_q.flag) && $past(st_q.r18[F_CNT_LO +: 2]) == 2'b00) |-> $past(st_q.lcnt) == 8'h04)
    else $error("count field zero did not need five cycles");
  AST_HOLD: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (st_q.flag && det_en && !ev_unl) |=> st_q.flag)
    else $error("lock flag dropped without a wide gap");
  AST_DROP: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    $fell(st_q.flag) |-> $past(ev_unl || !det_en))
    else $error("lock flag fell inside the unlock window");
  AST_DIS: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    st_q.r18[F_DIS] |=> (!st_q.flag && st_q.lk == LK_IDLE))
    else $error("disabled detector still active");
  AST_CSRC: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (st_q.r1a[5:0] == LKM_CSRC && !st_q.flag) |=> (st_q.pin_oe && !st_q.pin_o && !st_q.pin_src))
    else $error("pin not grounded while unlocked");
  AST_MUX: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (st_q.r17[7:2] == OSEL_FLAG) |=> (STATUS_PIN_O == $past(st_q.flag)))
    else $error("status pin does not follow lock flag");
  AST_CMP_N: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    ({1'b0, st_q.r1b[4:0]} == OSEL_CMPN) |=> (REFERENCE_WATCH_PIN_O == !$past(st_q.s_cmp[1])))
    else $error("watch pin not inverted comparator");
  AST_CTRL_KEEP: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (st_q.ctrl[F_SHRST] && !(apb_wr && PADDR_I == addr(IDX_CTRL))) |=> st_q.ctrl[F_SHRST])
    else $error("counter reset bit cleared itself");
endmodule // pdl_top
`default_nettype wire

// File: rtl/pdl_pkg.sv
// Constants, types and helper functions of the divider sync and lock detect block.
// Function
// - Enabled align pin resets both divider counters.
// - Align pin reset starts disabled.
// - Two enableable delays, three-bit code each.
// - Edge gap under lock threshold counts in-lock.
// - Unlock only beyond the wider unlock threshold.
// - Lock after programmed consecutive in-lock cycles.
// - One cycle beyond unlock threshold drops lock.
// - Window bit, pulse width, count set timing.
// - Lock flag muxed onto three pins.
// - Two analog lock pulse pin modes.
// - Current mode: source when locked, else ground.
// - Momentary unlock discharges pin at once.
// - Pin comparator readable, either polarity.
// - Fixed mode ignores swallow; main one bypasses.
// - Ratio is modulus times main plus swallow.
// - Counter reset bits are not self-clearing.
// - Count field zero needs five cycles.
// - Detector runs only while disable bit clear.
package pdl_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         CLK_NS     = 20;
  localparam int         LKW_HI_NS  = 80;
  localparam int         LKW_LO_NS  = 40;
  localparam logic [7:0] LKW_HI_CYC = 8'((LKW_HI_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] LKW_LO_CYC = 8'((LKW_LO_NS + CLK_NS - 1) / CLK_NS);
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_RCNT  = 8'h11;
  localparam logic [7:0] IDX_NCNT  = 8'h13;
  localparam logic [7:0] IDX_PSC   = 8'h16;
  localparam logic [7:0] IDX_STSEL = 8'h17;
  localparam logic [7:0] IDX_LKCFG = 8'h18;
  localparam logic [7:0] IDX_SYNC  = 8'h19;
  localparam logic [7:0] IDX_LKPIN = 8'h1A;
  localparam logic [7:0] IDX_RWSEL = 8'h1B;
  localparam logic [7:0] IDX_CTRL  = 8'h1E;
  localparam logic [7:0] IDX_STAT  = 8'h1F;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int F_A_LO     = 16;
  localparam int F_CNT_LO   = 5;
  localparam int F_WIN      = 4;
  localparam int F_DIS      = 3;
  localparam int F_PRST_LO  = 6;
  localparam int F_RDLY_LO  = 3;
  localparam int F_NDLY_LO  = 0;
  localparam int F_SHRST    = 0;
  localparam int F_RRST     = 1;
  localparam int F_ABRST    = 2;
  localparam int F_RDEN     = 3;
  localparam int F_NDEN     = 4;
  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [5:0] LKM_FLAG   = 6'h00;
  localparam logic [5:0] LKM_NPULSE = 6'h01;
  localparam logic [5:0] LKM_PPULSE = 6'h02;
  localparam logic [5:0] LKM_CSRC   = 6'h04;
  localparam logic [5:0] OSEL_FLAG  = 6'h01;
  localparam logic [5:0] OSEL_CMP   = 6'h02;
  localparam logic [5:0] OSEL_CMPN  = 6'h03;
  localparam logic [5:0] OSEL_FLAGN = 6'h04;
  localparam logic [2:0] PSC_FIX1   = 3'h0;
  localparam logic [2:0] PSC_FIX2   = 3'h1;
  localparam logic [2:0] PSC_FIX3   = 3'h2;
  localparam logic [2:0] PSC_DUAL2  = 3'h3;
  localparam logic [2:0] PSC_DUAL4  = 3'h4;
  localparam logic [2:0] PSC_DUAL8  = 3'h5;
  localparam logic [2:0] PSC_DUAL16 = 3'h6;
  localparam logic [2:0] PSC_DUAL32 = 3'h7;
  localparam logic [7:0] LKN_0      = 8'h05;
  localparam logic [7:0] LKN_1      = 8'h10;
  localparam logic [7:0] LKN_2      = 8'h40;
  localparam logic [7:0] LKN_3      = 8'hFF;

  typedef enum logic [1:0] {LK_IDLE = 2'b01, LK_MEAS = 2'b10} pdl_lk_e;

  // Byte address of a register index.
  function automatic logic [11:0] addr(input logic [7:0] idx);
    addr = {2'b00, idx, 2'b00};
  endfunction

  // Lock threshold in cycles from window bit and antibacklash width.
  function automatic logic [7:0] lk_thr(input logic win, input logic [1:0] abp);
    lk_thr = (win ? LKW_LO_CYC : LKW_HI_CYC) + {6'h00, abp};
  endfunction

  // Status style output select shared by two pins.
  function automatic logic osel(input logic [5:0] s, input logic f, input logic c);
    case (s)
      OSEL_FLAG:  osel = f;
      OSEL_CMP:   osel = c;
      OSEL_CMPN:  osel = ~c;
      OSEL_FLAGN: osel = ~f;
      default:    osel = 1'b0;
    endcase
  endfunction
endpackage

// File: rtl/pdl_path_if.sv
// Interface carrying one divider path from counter through delay cell.
`timescale 1ns/1ps
`default_nettype none
interface pdl_path_if;
  logic        tick;
  logic        clr;
  logic [18:0] ratio;
  logic        pulse;
  logic        dly_en;
  logic [2:0]  code;
  logic        out;
  modport div (input tick, input clr, input ratio, output pulse);
  modport dly (input pulse, input dly_en, input code, output out);
  modport top (output tick, output clr, output ratio, output dly_en, output code, input out);
endinterface
`default_nettype wire

// File: rtl/pdl_div.sv
// Programmable counter that emits one pulse per ratio input ticks.
`timescale 1ns/1ps
`default_nettype none
module pdl_div
  import pdl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  pdl_path_if.div  p
);
  typedef struct packed {
    logic [18:0] cnt;
    logic        pulse;
  } pdl_div_s;
  pdl_div_s q;
  pdl_div_s d;

  // Count ticks, wrap at the ratio, hold at zero while cleared.
  always_comb begin
    d = q;
    d.pulse = 1'b0;
    if (p.clr) begin
      d.cnt = 19'h00000;
    end else if (p.tick) begin
      if ({1'b0, q.cnt} + 20'h00001 >= {1'b0, p.ratio}) begin
        d.cnt = 19'h00000;
        d.pulse = 1'b1;
      end else begin
        d.cnt = q.cnt + 19'h00001;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign p.pulse = q.pulse;

  AST_DIV_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    p.clr |=> (!p.pulse && q.cnt == 19'h00000)) else $error("divider runs while cleared");
endmodule // pdl_div
`default_nettype wire

// File: rtl/pdl_dly.sv
// Delay cell that retards divider pulses by one cycle more than a three-bit code.
`timescale 1ns/1ps
`default_nettype none
module pdl_dly
  import pdl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  pdl_path_if.dly  p
);
  typedef struct packed {
    logic [7:0] sh;
    logic       out;
  } pdl_dly_s;
  pdl_dly_s q;
  pdl_dly_s d;

  // Shift the pulse along and tap it at the coded position.
  always_comb begin
    d = q;
    d.sh = {q.sh[6:0], p.pulse};
    d.out = p.dly_en ? d.sh[p.code] : p.pulse;
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign p.out = q.out;

  AST_DLY_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    (!p.dly_en && p.pulse) |=> p.out) else $error("undelayed pulse lost");
  AST_DLY_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
    (p.dly_en && p.code == 3'h2 && p.pulse) ##1 (p.dly_en && p.code == 3'h2) [*2]
    |=> p.out) else $error("delay code two not three cycles");
endmodule // pdl_dly
`default_nettype wire

// File: bench/pdl_far.sv
// Far-side model: comparator tick sources and the lock pin capacitor with its comparator.
`timescale 1ns/1ps
`default_nettype none
module pdl_far (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       fb_run_i,
  input  wire logic [3:0] skew_i,
  input  wire logic       oe_i,
  input  wire logic       o_i,
  input  wire logic       src_i,
  output logic            ref_o,
  output logic            fb_o,
  output logic            cmp_o
);
  logic [3:0] ph_q;
  logic [4:0] cap_q;
  logic [3:0] fb_ph;
  // Sixteen-cycle ticks keep the comparator period above the unlock gap.
  assign fb_ph = ph_q - skew_i;
  assign ref_o = ph_q < 4'h8;
  assign fb_o  = fb_run_i && (fb_ph < 4'h8);
  assign cmp_o = cap_q > 5'h13;
  // The capacitor charges from the source and empties at once when the pin is pulled low.
  always_ff @(posedge clk_i) begin
    ph_q <= rst_i ? 4'h0 : ph_q + 4'h1;
    if (rst_i || (oe_i && !o_i)) begin
      cap_q <= 5'h00;
    end else if (src_i && cap_q != 5'h1F) begin
      cap_q <= cap_q + 5'h01;
    end
  end
endmodule // pdl_far
`default_nettype wire

// File: bench/pdl_top_bench.sv
// Self-checking bench of the divider sync and lock detect block.
`timescale 1ns/1ps
`default_nettype none
module pdl_top_bench;
  import pdl_pkg::*;
  logic        clk, rst, psel, pen, pwr, fb_run, align_n, cmp, rtk, ftk, err;
  logic        oe, lo, src, stp, rwp, cr, cf;
  logic [3:0]  skew;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr;
  int          n_mismatch, checks_done;
  int          n_hi, n_lo, n_cr;
  pdl_top u_dut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .REF_TICK_I(rtk), .FB_TICK_I(ftk), .DIV_ALIGN_N_I(align_n),
    .LOCK_INDICATOR_PIN_I(cmp), .LOCK_INDICATOR_PIN_O(lo), .LOCK_INDICATOR_PIN_OE_O(oe),
    .LOCK_SRC_EN_O(src), .STATUS_PIN_O(stp), .REFERENCE_WATCH_PIN_O(rwp),
    .PHASE_CMP_REF_O(cr), .PHASE_CMP_FB_O(cf));
  pdl_far u_far (.clk_i(clk), .rst_i(rst), .fb_run_i(fb_run), .skew_i(skew), .oe_i(oe),
    .o_i(lo), .src_i(src), .ref_o(rtk), .fb_o(ftk), .cmp_o(cmp));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task close_out;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, held until pready is seen at a rising edge.
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k == 20) chk(32'h0, 32'h1);
    if (k == 20) close_out();
  endtask
  // Polls one status bit until it takes the wanted value.
  task ws(input int b, input logic v, input int lim);
    for (int k = 0; k < lim; k++) begin
      apb(1'b0, IDX_STAT, 32'h0);
      if (rd[b] === v) break;
    end
    chk({31'h0, rd[b]}, {31'h0, v});
    if (rd[b] !== v) close_out();
  endtask
  // Clock of 20 ns period.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Main sequence of scenarios.
  initial begin
    {psel, pen, pwr, fb_run, align_n, rst} = 6'b000011;
    {skew, paddr, pwdata} = '0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, IDX_SYNC, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, IDX_RCNT, 32'h1);
    apb(1'b1, IDX_NCNT, 32'h1);
    apb(1'b1, IDX_PSC, {29'h0, PSC_FIX1});
    apb(1'b1, IDX_STSEL, 32'h4);
    apb(1'b1, IDX_RWSEL, 32'h4);
    fb_run <= 1'b1;
    repeat (40) @(posedge clk);
    apb(1'b0, IDX_STAT, 32'h0);
    chk({31'h0, rd[0]}, 32'h0);
    ws(0, 1'b1, 60);
    repeat (3) @(posedge clk);
    chk({28'h0, stp, rwp, oe, lo}, 32'hB);
    skew <= 4'h8;
    repeat (120) @(posedge clk);
    apb(1'b0, IDX_STAT, 32'h0);
    chk({31'h0, rd[0]}, 32'h1);
    fb_run <= 1'b0;
    ws(0, 1'b0, 30);
    skew <= 4'h0;
    apb(1'b1, IDX_LKCFG, 32'h20);
    fb_run <= 1'b1;
    repeat (160) @(posedge clk);
    apb(1'b0, IDX_STAT, 32'h0);
    chk({31'h0, rd[0]}, 32'h0);
    ws(0, 1'b1, 200);
    apb(1'b1, IDX_LKPIN, {26'h0, LKM_CSRC});
    apb(1'b1, IDX_RWSEL, 32'h2);
    ws(1, 1'b1, 60);
    chk({29'h0, src, oe, rwp}, 32'h5);
    apb(1'b1, IDX_LKCFG, 32'h08);
    ws(1, 1'b0, 30);
    chk({30'h0, oe, lo}, 32'h2);
    align_n <= 1'b0;
    repeat (4) @(posedge clk);
    ws(2, 1'b0, 4);
    apb(1'b1, IDX_SYNC, 32'h40);
    ws(2, 1'b1, 10);
    align_n <= 1'b1;
    ws(2, 1'b0, 10);
    apb(1'b1, IDX_CTRL, 32'h1F);
    repeat (20) @(posedge clk);
    apb(1'b0, IDX_CTRL, 32'h0);
    chk(rd, 32'h1F);
    // Release the counters with both delays at code two and watch the low pulse mode.
    apb(1'b1, IDX_LKCFG, 32'h0);
    apb(1'b1, IDX_CTRL, 32'h18);
    apb(1'b1, IDX_SYNC, 32'h12);
    apb(1'b1, IDX_LKPIN, {26'h0, LKM_NPULSE});
    skew <= 4'h4;
    n_hi = 0;
    n_lo = 0;
    n_cr = 0;
    repeat (64) begin
      @(negedge clk);
      if (oe === 1'b1) n_hi++;
      if (lo !== 1'b0) n_lo++;
      if (cr === 1'b1) n_cr++;
    end
    chk({31'h0, n_hi != 0}, 32'h1);
    chk(n_lo, 32'h0);
    chk(n_cr, 32'h4);
    close_out();
  end
endmodule // pdl_top_bench
`default_nettype wire
